// ### include/rtc_calendar_alarm_consts.svh
// offsets, field positions, reset values and timing counts of the calendar clock
`ifndef RTC_CALENDAR_ALARM_CONSTS_SVH
`define RTC_CALENDAR_ALARM_CONSTS_SVH
// ----------------------------------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------------------------------
`define RTC_IDX_TIME_SM 6'h10
`define RTC_IDX_TIME_HW 6'h11
`define RTC_IDX_TIME_DM 6'h12
`define RTC_IDX_TIME_YR 6'h13
`define RTC_IDX_ALM_SM 6'h14
`define RTC_IDX_ALM_HW 6'h15
`define RTC_IDX_ALM_DM 6'h16
`define RTC_IDX_CTRL 6'h17
`define RTC_IDX_EVENTS 6'h18
// ----------------------------------------------------------------
// control, hour and event field positions
// ----------------------------------------------------------------
`define RTC_BIT_BCD 15
`define RTC_BIT_12HR 14
`define RTC_BIT_HALT_CMD 11
`define RTC_BIT_HALT_STS 10
`define RTC_BIT_ALM_CMD 9
`define RTC_BIT_ALM_STS 8
`define RTC_BIT_PM 5
`define RTC_EV_SECOND 0
`define RTC_EV_ALARM 1
`define RTC_EV_PERIODIC 2
// ----------------------------------------------------------------
// reset values and fixed values
// ----------------------------------------------------------------
`define RTC_RST_WDAY 3'h1
`define RTC_RST_DATE 6'h01
`define RTC_RST_MONTH 5'h01
`define RTC_CENTURY 8'h14
`define RTC_RST_PSEL 3'h2
`define RTC_RST_ALM_HALT 1'b1
// ----------------------------------------------------------------
// periodic selector codes
// ----------------------------------------------------------------
`define RTC_PSEL_SEC 3'h1
`define RTC_PSEL_MIN 3'h2
`define RTC_PSEL_HOUR 3'h3
`define RTC_PSEL_DAY 3'h4
`define RTC_PSEL_MONTH 3'h5
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RTC_CLK_HZ 20000000
`define RTC_OSC_HZ 32768
`define RTC_OSC_DIV (`RTC_CLK_HZ / `RTC_OSC_HZ)
`define RTC_SUB_TICKS 32768
`endif

// ### include/rtc_calendar_alarm_pkg.sv
// state type of the calendar clock
package rtc_calendar_alarm_pkg;
  typedef struct packed {
    logic [6:0] seconds_count;
    logic [6:0] minutes_count;
    logic [4:0] hours_count;
    logic [2:0] weekday;
    logic [5:0] day_of_month;
    logic [4:0] month_count;
    logic [7:0] year_in_century;
    logic [6:0] alarm_seconds;
    logic [6:0] alarm_minutes;
    logic [5:0] alarm_hours;
    logic [3:0] alarm_weekday;
    logic [5:0] alarm_day_of_month;
    logic [4:0] alarm_month;
    logic bcd_mode;
    logic twelve_hour_select;
    logic counter_halted_status;
    logic alarm_halted_status;
    logic [2:0] periodic_pulse_select;
    logic [3:0] square_wave_select;
    logic [15:0] osc_div;
    logic [15:0] sub_ticks;
    logic [2:0] event_flags;
    logic alarm_match_q;
    logic periodic_out;
    logic square_out;
    logic wb_ack;
    logic [31:0] wb_dat;
  } rtc_state_s;
endpackage

// ### design/rtc_calendar_alarm.sv
// calendar clock with alarm, periodic pulse and square wave behind classic wishbone
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "rtc_calendar_alarm_consts.svh"

module rtc_calendar_alarm #(
  parameter int OSC_DIV = `RTC_OSC_DIV,
  parameter int SUB_TICKS = `RTC_SUB_TICKS,
  parameter int TRIM_TICKS = 0
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // timing outputs
  output logic o_periodic,
  output logic o_square_wave
);

  rtc_calendar_alarm_pkg::rtc_state_s s;
  rtc_calendar_alarm_pkg::rtc_state_s next_s;

  // ----------------------------------------------------------------
  // coding helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] to_bcd(input logic [7:0] v);
    return {4'(v / 8'h0A), 4'(v % 8'h0A)};
  endfunction

  function automatic logic [7:0] from_bcd(input logic [7:0] v);
    return 8'(v[7:4] * 8'h0A + {4'h0, v[3:0]});
  endfunction

  function automatic logic [7:0] enc(input logic bcd, input logic [7:0] v);
    return bcd ? to_bcd(v) : v;
  endfunction

  function automatic logic [7:0] dec(input logic bcd, input logic [7:0] v);
    return bcd ? from_bcd(v) : v;
  endfunction

  function automatic logic [5:0] days_in_month(input logic [4:0] m, input logic [7:0] y);
    logic [5:0] d;
    d = 6'h1F;
    case (m)
      5'h04, 5'h06, 5'h09, 5'h0B: d = 6'h1E;
      5'h02: d = (y[1:0] == 2'h0) ? 6'h1D : 6'h1C;
      default: d = 6'h1F;
    endcase
    return d;
  endfunction

  // ----------------------------------------------------------------
  // combinational views of the time
  // ----------------------------------------------------------------
  logic [7:0] sec_e;
  logic [7:0] min_e;
  logic [5:0] hour_e;
  logic [4:0] hour12;
  logic [7:0] date_e;
  logic [7:0] month_e;
  logic [7:0] year_e;
  logic [7:0] century_e;
  logic match_now;
  logic [31:0] rd_word;
  logic [15:0] wv;
  logic [5:0] idx;
  logic req;
  logic wr_go;

  always_comb begin
    sec_e = enc(s.bcd_mode, {1'b0, s.seconds_count});
    min_e = enc(s.bcd_mode, {1'b0, s.minutes_count});
    hour12 = (s.hours_count >= 5'd12) ? 5'(s.hours_count - 5'd12) : s.hours_count;
    if (hour12 == 5'h00) begin
      hour12 = 5'd12;
    end
    if (s.twelve_hour_select) begin
      hour_e = {s.hours_count >= 5'd12, 5'(enc(s.bcd_mode, {3'h0, hour12}))};
    end else begin
      hour_e = 6'(enc(s.bcd_mode, {3'h0, s.hours_count}));
    end
    date_e = enc(s.bcd_mode, {2'h0, s.day_of_month});
    month_e = enc(s.bcd_mode, {3'h0, s.month_count});
    year_e = enc(s.bcd_mode, s.year_in_century);
    century_e = enc(s.bcd_mode, `RTC_CENTURY);
    // all-ones fields are wildcards
    match_now = ((s.alarm_seconds == 7'h7F) || (s.alarm_seconds == sec_e[6:0]))
      && ((s.alarm_minutes == 7'h7F) || (s.alarm_minutes == min_e[6:0]))
      && ((s.alarm_hours[4:0] == 5'h1F) || (s.alarm_hours == hour_e))
      && ((s.alarm_weekday == 4'hF) || (s.alarm_weekday == {1'b0, s.weekday}))
      && ((s.alarm_day_of_month == 6'h3F) || (s.alarm_day_of_month == date_e[5:0]))
      && ((s.alarm_month == 5'h1F) || (s.alarm_month == month_e[4:0]));
  end

  // ----------------------------------------------------------------
  // register read view
  // ----------------------------------------------------------------
  assign idx = i_wb_adr[7:2];
  assign req = i_wb_cyc & i_wb_stb;
  assign wr_go = req & i_wb_we & s.wb_ack;

  always_comb begin
    rd_word = 32'h0000_0000;
    case (idx)
      `RTC_IDX_TIME_SM: rd_word = {17'h0, min_e[6:0], 1'b0, sec_e[6:0]};
      `RTC_IDX_TIME_HW: rd_word = {21'h0, s.weekday, 2'h0, hour_e};
      `RTC_IDX_TIME_DM: rd_word = {19'h0, month_e[4:0], 2'h0, date_e[5:0]};
      `RTC_IDX_TIME_YR: rd_word = {18'h0, century_e[5:0], year_e};
      `RTC_IDX_ALM_SM: rd_word = {17'h0, s.alarm_minutes, 1'b0, s.alarm_seconds};
      `RTC_IDX_ALM_HW: rd_word = {20'h0, s.alarm_weekday, 2'h0, s.alarm_hours};
      `RTC_IDX_ALM_DM: rd_word = {19'h0, s.alarm_month, 2'h0, s.alarm_day_of_month};
      `RTC_IDX_CTRL: rd_word = {16'h0, s.bcd_mode, s.twelve_hour_select, 2'h0,
        s.counter_halted_status, s.counter_halted_status, s.alarm_halted_status,
        s.alarm_halted_status, 1'b0, s.periodic_pulse_select, s.square_wave_select};
      `RTC_IDX_EVENTS: rd_word = {29'h0, s.event_flags};
      default: rd_word = 32'h0000_0000;
    endcase
    // byte lanes not selected keep the current contents
    wv[7:0] = i_wb_sel[0] ? i_wb_dat[7:0] : rd_word[7:0];
    wv[15:8] = i_wb_sel[1] ? i_wb_dat[15:8] : rd_word[15:8];
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic tick;
  logic sec_roll;
  logic min_roll;
  logic hour_roll;
  logic day_roll;
  logic month_roll;
  logic per_event;
  logic [2:0] ev_set;
  logic [2:0] ev_clr;
  logic [7:0] hw;
  logic [3:0] sq_idx;

  always_comb begin
    next_s = s;
    hw = 8'h00;
    tick = (s.osc_div == 16'(OSC_DIV - 1));
    next_s.osc_div = tick ? 16'h0000 : 16'(s.osc_div + 16'h0001);
    // a trimmed second ends early, clipping the last square wave period
    sec_roll = tick && !s.counter_halted_status
      && (s.sub_ticks == 16'(SUB_TICKS - 1 - TRIM_TICKS));
    min_roll = sec_roll && (s.seconds_count == 7'd59);
    hour_roll = min_roll && (s.minutes_count == 7'd59);
    day_roll = hour_roll && (s.hours_count == 5'd23);
    month_roll = day_roll
      && (s.day_of_month == days_in_month(s.month_count, s.year_in_century));
    if (tick && !s.counter_halted_status) begin
      next_s.sub_ticks = sec_roll ? 16'h0000 : 16'(s.sub_ticks + 16'h0001);
    end
    // calendar cascade
    if (sec_roll) begin
      next_s.seconds_count = min_roll ? 7'h00 : 7'(s.seconds_count + 7'h01);
    end
    if (min_roll) begin
      next_s.minutes_count = hour_roll ? 7'h00 : 7'(s.minutes_count + 7'h01);
    end
    if (hour_roll) begin
      next_s.hours_count = day_roll ? 5'h00 : 5'(s.hours_count + 5'h01);
    end
    if (day_roll) begin
      next_s.weekday = (s.weekday == 3'd7) ? 3'h1 : 3'(s.weekday + 3'h1);
      next_s.day_of_month = month_roll ? 6'h01 : 6'(s.day_of_month + 6'h01);
    end
    if (month_roll) begin
      if (s.month_count == 5'd12) begin
        next_s.month_count = 5'h01;
        next_s.year_in_century = (s.year_in_century == 8'd99) ? 8'h00
          : 8'(s.year_in_century + 8'h01);
      end else begin
        next_s.month_count = 5'(s.month_count + 5'h01);
      end
    end
    // periodic pulse, one 32k tick wide
    case (s.periodic_pulse_select)
      `RTC_PSEL_SEC: per_event = sec_roll;
      `RTC_PSEL_MIN: per_event = min_roll;
      `RTC_PSEL_HOUR: per_event = hour_roll;
      `RTC_PSEL_DAY: per_event = day_roll;
      `RTC_PSEL_MONTH: per_event = month_roll;
      default: per_event = 1'b0;
    endcase
    if (per_event && !s.counter_halted_status) begin
      next_s.periodic_out = 1'b1;
    end else if (tick || s.counter_halted_status) begin
      next_s.periodic_out = 1'b0;
    end
    // square wave from the sub-second counter
    sq_idx = 4'(4'hF - s.square_wave_select);
    next_s.square_out = (s.square_wave_select != 4'h0) && s.sub_ticks[sq_idx];
    // alarm edge detect
    next_s.alarm_match_q = match_now && !s.alarm_halted_status;
    ev_set = 3'h0;
    ev_set[`RTC_EV_SECOND] = sec_roll;
    ev_set[`RTC_EV_ALARM] = next_s.alarm_match_q && !s.alarm_match_q;
    ev_set[`RTC_EV_PERIODIC] = next_s.periodic_out && !s.periodic_out;
    // wishbone: answer one cycle after the request, act at the ack edge
    next_s.wb_ack = req && !s.wb_ack;
    if (req && !s.wb_ack) begin
      next_s.wb_dat = rd_word;
    end
    ev_clr = 3'h0;
    if (req && !i_wb_we && s.wb_ack && (idx == `RTC_IDX_EVENTS)) begin
      ev_clr = s.wb_dat[2:0];
    end
    next_s.event_flags = (s.event_flags & ~ev_clr) | ev_set;
    if (wr_go) begin
      case (idx)
        `RTC_IDX_TIME_SM: begin
          next_s.minutes_count = 7'(dec(s.bcd_mode, {1'b0, wv[14:8]}));
          next_s.seconds_count = 7'(dec(s.bcd_mode, {1'b0, wv[6:0]}));
          next_s.sub_ticks = 16'h0000;
        end
        `RTC_IDX_TIME_HW: begin
          next_s.weekday = wv[10:8];
          if (s.twelve_hour_select) begin
            hw = dec(s.bcd_mode, {3'h0, wv[4:0]});
            hw = (hw == 8'd12) ? 8'h00 : hw;
            next_s.hours_count = 5'(hw + (wv[`RTC_BIT_PM] ? 8'd12 : 8'd0));
          end else begin
            next_s.hours_count = 5'(dec(s.bcd_mode, {2'h0, wv[5:0]}));
          end
        end
        `RTC_IDX_TIME_DM: begin
          next_s.month_count = 5'(dec(s.bcd_mode, {3'h0, wv[12:8]}));
          next_s.day_of_month = 6'(dec(s.bcd_mode, {2'h0, wv[5:0]}));
        end
        `RTC_IDX_TIME_YR: next_s.year_in_century = dec(s.bcd_mode, wv[7:0]);
        `RTC_IDX_ALM_SM: begin
          next_s.alarm_minutes = wv[14:8];
          next_s.alarm_seconds = wv[6:0];
        end
        `RTC_IDX_ALM_HW: begin
          next_s.alarm_weekday = wv[11:8];
          next_s.alarm_hours = wv[5:0];
        end
        `RTC_IDX_ALM_DM: begin
          next_s.alarm_month = wv[12:8];
          next_s.alarm_day_of_month = wv[5:0];
        end
        `RTC_IDX_CTRL: begin
          next_s.bcd_mode = wv[`RTC_BIT_BCD];
          next_s.twelve_hour_select = wv[`RTC_BIT_12HR];
          next_s.counter_halted_status = wv[`RTC_BIT_HALT_CMD];
          next_s.alarm_halted_status = wv[`RTC_BIT_ALM_CMD];
          next_s.periodic_pulse_select = wv[6:4];
          next_s.square_wave_select = wv[3:0];
        end
        default: next_s.square_wave_select = s.square_wave_select;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      s <= '0;
      s.weekday <= `RTC_RST_WDAY;
      s.day_of_month <= `RTC_RST_DATE;
      s.month_count <= `RTC_RST_MONTH;
      s.alarm_halted_status <= `RTC_RST_ALM_HALT;
      s.periodic_pulse_select <= `RTC_RST_PSEL;
    end else begin
      s <= next_s;
    end
  end

  assign o_wb_dat = s.wb_dat;
  assign o_wb_ack = s.wb_ack;
  assign o_periodic = s.periodic_out;
  assign o_square_wave = s.square_out;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_last_second;
    sec_roll && (s.seconds_count == 7'd59) && !wr_go;
  endsequence

  property p_sec_range;
    (s.seconds_count <= 7'd59) && (s.minutes_count <= 7'd59);
  endproperty
  a_sec_range: assert property (p_sec_range) else $error("seconds or minutes out of range");

  property p_wday_range;
    (s.weekday >= 3'd1) && (s.weekday <= 3'd7);
  endproperty
  a_wday_range: assert property (p_wday_range) else $error("weekday out of range");

  property p_cal_range;
    (s.hours_count <= 5'd23) && (s.month_count >= 5'd1) && (s.month_count <= 5'd12)
      && (s.day_of_month >= 6'd1) && (s.day_of_month <= 6'd31);
  endproperty
  a_cal_range: assert property (p_cal_range) else $error("calendar field out of range");

  property p_minute_carry;
    s_last_second |=> (s.seconds_count == 7'd0)
      && (s.minutes_count != $past(s.minutes_count));
  endproperty
  a_minute_carry: assert property (p_minute_carry) else $error("minute carry missing");

  property p_no_pulse_halted;
    s.counter_halted_status |=> !o_periodic;
  endproperty
  a_no_pulse_halted: assert property (p_no_pulse_halted) else $error("pulse while halted");

  property p_alarm_cause;
    $rose(s.event_flags[`RTC_EV_ALARM]) |-> s.alarm_match_q && !$past(s.alarm_match_q);
  endproperty
  a_alarm_cause: assert property (p_alarm_cause) else $error("alarm flag without match");

  property p_second_flag;
    sec_roll |=> s.event_flags[`RTC_EV_SECOND];
  endproperty
  a_second_flag: assert property (p_second_flag) else $error("second tick flag lost");

  property p_halt_write;
    wr_go && (idx == `RTC_IDX_CTRL)
      |=> s.counter_halted_status == $past(wv[`RTC_BIT_HALT_CMD]);
  endproperty
  a_halt_write: assert property (p_halt_write) else $error("halt status not updated");

  property p_pulse_width;
    $rose(o_periodic) && !s.counter_halted_status |-> o_periodic [*2];
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("periodic pulse too short");

endmodule

// ### dv/tb_top.sv
// self-checking bench of the calendar clock over classic wishbone
`timescale 1ns/100ps
`include "rtc_calendar_alarm_consts.svh"
module tb_top;
  // ----------------------------------------------------------------
  // clock, reset and bus signals
  // ----------------------------------------------------------------
  // short counts keep one second at 128 clocks
  localparam int DIV = 2;
  localparam int SUB = 64;
  localparam int SEC = DIV * SUB;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_wb_cyc = 1'b0;
  logic i_wb_stb = 1'b0;
  logic i_wb_we = 1'b0;
  logic [7:0] i_wb_adr = 8'h00;
  logic [3:0] i_wb_sel = 4'h0;
  logic [31:0] i_wb_dat = 32'h00000000;
  logic [31:0] o_wb_dat;
  logic o_wb_ack;
  logic o_periodic;
  logic o_square_wave;
  logic [31:0] q;
  int checks = 0;
  int mismatches = 0;
  int pulses = 0;
  int high_len = 0;
  int p0;
  int n;

  always #25 i_clk = ~i_clk;

  rtc_calendar_alarm #(.OSC_DIV(DIV), .SUB_TICKS(SUB), .TRIM_TICKS(0)) uut (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we),
    .i_wb_adr(i_wb_adr),
    .i_wb_sel(i_wb_sel),
    .i_wb_dat(i_wb_dat),
    .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack),
    .o_periodic(o_periodic),
    .o_square_wave(o_square_wave)
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one classic cycle, entered just after a rising edge
  task automatic wb(input logic we, input logic [5:0] idx, input logic [15:0] d,
      input logic [3:0] sel, output logic [31:0] rq);
    int t;
    t = 0;
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= we;
    i_wb_adr <= {idx, 2'b00};
    i_wb_sel <= sel;
    i_wb_dat <= {16'h0000, d};
    @(posedge i_clk);
    while (o_wb_ack !== 1'b1) begin
      @(posedge i_clk);
      t++;
    end
    rq = o_wb_dat;
    check("bus ack cycles", 1, t);
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    i_wb_we <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [15:0] d);
    logic [31:0] rq;
    wb(1'b1, idx, d, 4'h3, rq);
  endtask

  task automatic rd(input logic [5:0] idx, input logic [15:0] exp, input string what);
    logic [31:0] rq;
    wb(1'b0, idx, 16'h0000, 4'h3, rq);
    check(what, {16'h0000, exp}, rq);
  endtask

  // halting first keeps a partial update from ticking
  task automatic set_time(input logic [15:0] ctrl, input logic [15:0] sm,
      input logic [15:0] hw, input logic [15:0] dm, input logic [15:0] yr);
    wr(`RTC_IDX_CTRL, ctrl | 16'h0800);
    wr(`RTC_IDX_TIME_SM, sm);
    wr(`RTC_IDX_TIME_HW, hw);
    wr(`RTC_IDX_TIME_DM, dm);
    wr(`RTC_IDX_TIME_YR, yr);
    wr(`RTC_IDX_CTRL, ctrl);
  endtask

  task automatic sq_high(output int len);
    int t;
    len = 0;
    t = 0;
    // skip the sample still made under the old selector
    @(posedge i_clk);
    while (o_square_wave !== 1'b0 && t < 300) begin
      @(posedge i_clk);
      t++;
    end
    while (o_square_wave !== 1'b1 && t < 300) begin
      @(posedge i_clk);
      t++;
    end
    while (o_square_wave === 1'b1 && t < 300) begin
      @(posedge i_clk);
      len++;
      t++;
    end
  endtask

  // ----------------------------------------------------------------
  // periodic pulse monitor
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    if (o_periodic === 1'b1) begin
      if (high_len == 0) begin
        pulses++;
      end
      high_len++;
    end else begin
      if (high_len != 0) begin
        check("periodic width", DIV, high_len);
      end
      high_len = 0;
    end
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    rd(`RTC_IDX_TIME_SM, 16'h0000, "time sec min");
    rd(`RTC_IDX_TIME_HW, 16'h0100, "time hr wday");
    rd(`RTC_IDX_TIME_DM, 16'h0101, "time date month");
    rd(`RTC_IDX_TIME_YR, 16'h1400, "time year");
    rd(`RTC_IDX_ALM_SM, 16'h0000, "alarm sec min");
    rd(`RTC_IDX_ALM_HW, 16'h0000, "alarm hr wday");
    rd(`RTC_IDX_ALM_DM, 16'h0000, "alarm date");
    rd(`RTC_IDX_CTRL, 16'h0320, "ctrl");
    wr(6'h20, 16'hFFFF);
    rd(6'h20, 16'h0000, "unmapped");
    // halted counter holds its value
    wr(`RTC_IDX_CTRL, 16'h0B20);
    rd(`RTC_IDX_CTRL, 16'h0F20, "halt status");
    wr(`RTC_IDX_TIME_SM, 16'h3B3A);
    wr(`RTC_IDX_TIME_HW, 16'h0717);
    wr(`RTC_IDX_TIME_DM, 16'h021C);
    wr(`RTC_IDX_TIME_YR, 16'h0003);
    repeat (2 * SEC) @(posedge i_clk);
    rd(`RTC_IDX_TIME_SM, 16'h3B3A, "halted sec");
    wr(`RTC_IDX_CTRL, 16'h0320);
    repeat (SEC * 5 / 2) @(posedge i_clk);
    rd(`RTC_IDX_TIME_SM, 16'h0000, "rolled sec min");
    rd(`RTC_IDX_TIME_HW, 16'h0100, "rolled hr wday");
    rd(`RTC_IDX_TIME_DM, 16'h0301, "feb end");
    rd(`RTC_IDX_TIME_YR, 16'h1403, "year kept");
    rd(`RTC_IDX_EVENTS, 16'h0005, "events");
    rd(`RTC_IDX_EVENTS, 16'h0000, "events cleared");
    set_time(16'h0320, 16'h3B3B, 16'h0717, 16'h021C, 16'h0004);
    repeat (SEC * 3 / 2) @(posedge i_clk);
    rd(`RTC_IDX_TIME_DM, 16'h021D, "leap feb");
    // every selector code across a full calendar rollover
    for (int c = 0; c < 8; c++) begin
      set_time(16'h0300 | 16'(c << 4), 16'h3B3A, 16'h0717, 16'h0C1F, 16'h0063);
      p0 = pulses;
      repeat (SEC * 5 / 2) @(posedge i_clk);
      n = (c == 1) ? 2 : ((c >= 2 && c <= 5) ? 1 : 0);
      check("periodic count", n, pulses - p0);
    end
    rd(`RTC_IDX_TIME_DM, 16'h0101, "new year date");
    rd(`RTC_IDX_TIME_YR, 16'h1400, "year wrap");
    // hit, minutes mismatch, alarms halted
    for (int k = 0; k < 3; k++) begin
      set_time(16'h0320, 16'h0A37, 16'h0305, 16'h060F, 16'h0014);
      wr(`RTC_IDX_ALM_SM, (k == 1) ? 16'h0B39 : 16'h7F39);
      wr(`RTC_IDX_ALM_HW, 16'h0F3F);
      wr(`RTC_IDX_ALM_DM, 16'h1F3F);
      wb(1'b0, `RTC_IDX_EVENTS, 16'h0000, 4'h3, q);
      wr(`RTC_IDX_CTRL, (k == 2) ? 16'h0320 : 16'h0020);
      repeat (SEC * 3) @(posedge i_clk);
      wb(1'b0, `RTC_IDX_EVENTS, 16'h0000, 4'h3, q);
      check("alarm flag", (k == 0), q[1]);
    end
    // coding and hour modes on a halted clock
    set_time(16'h0B20, 16'h1E2D, 16'h020D, 16'h0101, 16'h0014);
    wr(`RTC_IDX_CTRL, 16'hCB20);
    rd(`RTC_IDX_TIME_SM, 16'h3045, "bcd sec min");
    rd(`RTC_IDX_TIME_HW, 16'h0221, "12h pm");
    rd(`RTC_IDX_TIME_YR, 16'h2020, "bcd year");
    wr(`RTC_IDX_CTRL, 16'h8B20);
    rd(`RTC_IDX_TIME_HW, 16'h0213, "24h bcd");
    wr(`RTC_IDX_CTRL, 16'h0B20);
    wb(1'b1, `RTC_IDX_TIME_SM, 16'h0005, 4'h1, q);
    rd(`RTC_IDX_TIME_SM, 16'h1E05, "low lane");
    wr(`RTC_IDX_TIME_YR, 16'hFF63);
    rd(`RTC_IDX_TIME_YR, 16'h1463, "century fixed");
    // square wave high time for codes 10 to 15, then off
    for (int c = 10; c < 16; c++) begin
      wr(`RTC_IDX_CTRL, 16'h0320 | 16'(c));
      sq_high(n);
      check("square high", (1 << (15 - c)) * DIV, n);
    end
    wr(`RTC_IDX_CTRL, 16'h0320);
    sq_high(n);
    check("square off", 0, n);
    check("square off level", 0, o_square_wave);
    close_out();
  end

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial begin
    #(50 * 20000);
    mismatches++;
    close_out();
  end
endmodule
